// ===== rtl/accel_regs_defs.svh
// Offsets, field positions, reset values and timing counts for the test/reset/calibration bank.
// ============================================================================
// Summary of operation
// - Z drive bit 2 enables positive stimulus.
// - Z drive bit 3 enables negative stimulus.
// - Any reset returns serial port to four-wire.
// - Reset bit 6 forces full reset, self-clears.
// - Reload bit 7 copies memory into registers.
// - Reload bit stays set until host clears.
// - Busy flag at status bit 5 during reload.
// - Counts 1 to 254 capture that many samples.
// - Count 255 samples until mode field changes.
// - Software rate makes count a shadow register.
// - Signed 15-bit offset added to each result.
// - X offset low/high layout with gain bit 8.
// - Y offset low/high layout with gain bit 8.
// - Offsets reset to factory values, host writable.
// - Gain is unsigned 9-bit, byte plus high bit.
`ifndef ACCEL_REGS_DEFS_SVH
`define ACCEL_REGS_DEFS_SVH

// ============================================================================
// Register offsets.
`define ADDR_STATUS         8'h01
`define ADDR_MODE           8'h10
`define ADDR_RATE1          8'h11
`define ADDR_Z_DRIVE        8'h22
`define ADDR_SOFT_RESET     8'h24
`define ADDR_INIT_TWO       8'h28
`define ADDR_TRIG_COUNT     8'h29
`define ADDR_X_OFF_LOW      8'h2a
`define ADDR_X_OFF_HIGH     8'h2b
`define ADDR_Y_OFF_LOW      8'h2c
`define ADDR_Y_OFF_HIGH     8'h2d

// ============================================================================
// Field positions.
`define BIT_Z_POS           2
`define BIT_Z_NEG           3
`define BIT_RESET           6
`define BIT_RELOAD          7
`define BIT_BUSY            5
`define BIT_GAIN_MSB        7
`define COUNT_CONTINUOUS    8'hff

// ============================================================================
// Reset values.
`define RST_BYTE            8'h00

// ============================================================================
// Timing counts: duration of an internal memory reload sequence in cycles.
`define RELOAD_CYCLES       16

`endif

// ===== rtl/accel_regs_pkg.sv
// Types shared by the register bank and its trigger sequencer.
package accel_regs_pkg;
  // States of the one-shot sample sequencer.
  typedef enum logic [1:0] {SEQ_IDLE, SEQ_COUNT, SEQ_CONT} seq_state_type;
  // States of the memory copy engine.
  typedef enum logic [1:0] {MEM_IDLE, MEM_COPY} mem_state_type;
endpackage

// ===== rtl/oneshot_sequencer.sv
// One-shot sample sequencer driven by the programmed sample count.
`timescale 1ns/100ps
`include "accel_regs_defs.svh"
module oneshot_sequencer import accel_regs_pkg::*; (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       trigger,
  input  wire logic [7:0] count,
  input  wire logic       mode_change,
  input  wire logic       sample_tick,
  output logic            sample_en,
  output logic            seq_active
);
  seq_state_type state_r;  // Sequencer state.
  logic [7:0]    left_r;   // Samples still to take.

  // ==========================================================================
  // Sequencer. Count zero is treated as nothing to take.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= SEQ_IDLE;
      left_r  <= 8'h00;
    end else begin
      case (state_r)
        SEQ_IDLE: begin
          if (trigger && count == `COUNT_CONTINUOUS) begin
            state_r <= SEQ_CONT;
          end else if (trigger && count != 8'h00) begin
            state_r <= SEQ_COUNT;
            left_r  <= count;
          end
        end
        SEQ_COUNT: begin
          if (sample_tick) begin
            left_r <= left_r - 8'h01;
            if (left_r == 8'h01) begin
              state_r <= SEQ_IDLE;
            end
          end
        end
        SEQ_CONT: begin
          if (mode_change) begin
            state_r <= SEQ_IDLE;
          end
        end
        default: state_r <= SEQ_IDLE;
      endcase
    end
  end

  assign seq_active = (state_r != SEQ_IDLE);
  assign sample_en  = seq_active && sample_tick;

  // ==========================================================================
  // Checks.
  cont_stop_a: assert property (@(posedge clk) disable iff (!rst_n)
    state_r == SEQ_CONT && mode_change |=> state_r == SEQ_IDLE)
    else $error("continuous sampling did not stop on mode change");
  last_stop_a: assert property (@(posedge clk) disable iff (!rst_n)
    state_r == SEQ_COUNT && sample_tick && left_r == 8'h01 |=> !seq_active)
    else $error("counted sampling did not stop after last sample");
  cont_cov_c: cover property (@(posedge clk) disable iff (!rst_n) state_r == SEQ_CONT);
endmodule

// ===== rtl/accel_test_reset_calib_regs.sv
// Test drive, soft reset/reload, init, trigger count and X/Y offset register bank.
`timescale 1ns/100ps
`include "accel_regs_defs.svh"
module accel_test_reset_calib_regs import accel_regs_pkg::*; #(
  parameter logic [14:0] X_OFFSET_FACTORY = 15'h0000, // Factory image, per part.
  parameter logic [14:0] Y_OFFSET_FACTORY = 15'h0000, // Factory image, per part.
  parameter logic [8:0]  X_GAIN_FACTORY   = 9'h100,   // Factory image, per part.
  parameter logic [8:0]  Y_GAIN_FACTORY   = 9'h100    // Factory image, per part.
) (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        wr_en,
  input  wire logic        rd_en,
  input  wire logic [7:0]  addr,
  input  wire logic [7:0]  wr_data,
  output logic      [7:0]  rd_data,
  input  wire logic [2:0]  mode_field,
  input  wire logic [2:0]  rate_select,
  input  wire logic        software_defined_rate,
  input  wire logic        trigger,
  input  wire logic        sample_tick,
  input  wire logic signed [15:0] x_accel,
  input  wire logic signed [15:0] y_accel,
  output logic             z_positive_drive,
  output logic             z_negative_drive,
  output logic             spi_three_wire,
  output logic             reload_busy,
  output logic [8:0]       x_gain_value,
  output logic [8:0]       y_gain_value,
  output logic signed [15:0] x_extended_output,
  output logic signed [15:0] y_extended_output,
  output logic [7:0]       sdr_shadow,
  output logic             sample_en,
  output logic             seq_active
);
  logic [7:0]    z_drive_register_r;     // Z self-test drive bits.
  logic          reload_req_r;           // Reload request bit, host cleared.
  logic          soft_rst_r;             // Pending forced reset pulse.
  logic [7:0]    init_zero_two_r;        // Initialisation byte.
  logic [7:0]    oneshot_sample_count_r; // Count, or shadow value.
  logic [14:0]   x_offset_value_r;       // X signed offset.
  logic [14:0]   y_offset_value_r;       // Y signed offset.
  logic          x_gain_msb_r;           // X gain bit 8.
  logic          y_gain_msb_r;           // Y gain bit 8.
  logic          three_wire_r;           // Serial port three-wire selection.
  mem_state_type mem_state_r;            // Memory copy engine state.
  logic [4:0]    copy_cnt_r;             // Copy progress counter.
  logic [2:0]    mode_last_r;            // Last mode field seen.
  logic          reload_go;              // Start of a memory copy.
  logic          soft_go;                // Forced reset request.
  logic [4:0]    busy_run_r;             // Busy cycles seen in the current copy.

  // Decode a write to one offset.
  function automatic logic hit(input logic [7:0] a);
    hit = wr_en && addr == a;
  endfunction

  // Sign-extend a 15-bit offset and add it to a result.
  function automatic logic signed [15:0] add_off(input logic signed [15:0] v,
                                                 input logic [14:0] o);
    add_off = v + {o[14], o};
  endfunction

  assign soft_go   = hit(`ADDR_SOFT_RESET) && wr_data[`BIT_RESET];
  assign reload_go = hit(`ADDR_SOFT_RESET) && wr_data[`BIT_RELOAD] && !reload_req_r;

  // ==========================================================================
  // Forced reset pulse: one cycle, then the bit reads zero again.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      soft_rst_r <= 1'b0;
    end else begin
      soft_rst_r <= soft_go;
    end
  end

  // ==========================================================================
  // Self-test drive; host keeps reserved bits zero, stored as written.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      z_drive_register_r <= `RST_BYTE;
    end else if (soft_rst_r) begin
      z_drive_register_r <= `RST_BYTE;
    end else if (hit(`ADDR_Z_DRIVE)) begin
      z_drive_register_r <= wr_data;
    end
  end
  assign z_positive_drive = z_drive_register_r[`BIT_Z_POS];
  assign z_negative_drive = z_drive_register_r[`BIT_Z_NEG];

  // ==========================================================================
  // Serial port wire mode: any reset returns it to four-wire. Setting it to
  // three-wire belongs to another register outside this bank, so it only clears here.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      three_wire_r <= 1'b0;
    end else if (soft_rst_r) begin
      three_wire_r <= 1'b0;
    end
  end
  assign spi_three_wire = three_wire_r;

  // ==========================================================================
  // Reload request bit, held until the host writes it back to zero.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reload_req_r <= 1'b0;
    end else if (soft_rst_r) begin
      reload_req_r <= 1'b0;
    end else if (hit(`ADDR_SOFT_RESET)) begin
      reload_req_r <= wr_data[`BIT_RELOAD];
    end
  end

  // ==========================================================================
  // Memory copy engine: busy for a fixed number of cycles per copy.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mem_state_r <= MEM_IDLE;
      copy_cnt_r  <= 5'h00;
    end else begin
      case (mem_state_r)
        MEM_IDLE: begin
          if (reload_go || soft_rst_r) begin
            mem_state_r <= MEM_COPY;
            copy_cnt_r  <= 5'(`RELOAD_CYCLES - 1);
          end
        end
        MEM_COPY: begin
          if (copy_cnt_r == 5'h00) begin
            mem_state_r <= MEM_IDLE;
          end else begin
            copy_cnt_r <= copy_cnt_r - 5'h01;
          end
        end
        default: mem_state_r <= MEM_IDLE;
      endcase
    end
  end
  assign reload_busy = (mem_state_r == MEM_COPY);

  // Length of the current busy stretch, for the checks below. A counter keeps
  // the length check small for copy lengths up to 31 cycles.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      busy_run_r <= 5'h00;
    end else if (reload_busy) begin
      busy_run_r <= busy_run_r + 5'h01;
    end else begin
      busy_run_r <= 5'h00;
    end
  end

  // ==========================================================================
  // Init and trigger count bytes.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      init_zero_two_r        <= `RST_BYTE;
      oneshot_sample_count_r <= `RST_BYTE;
    end else if (soft_rst_r) begin
      init_zero_two_r        <= `RST_BYTE;
      oneshot_sample_count_r <= `RST_BYTE;
    end else begin
      if (hit(`ADDR_INIT_TWO)) begin
        init_zero_two_r <= wr_data;
      end
      if (hit(`ADDR_TRIG_COUNT)) begin
        oneshot_sample_count_r <= wr_data;
      end
    end
  end
  // Under software rate the count byte is copied to sdr_shadow; rate_select is not used here.
  // Registered so the shadow view never glitches while the rate choice moves.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sdr_shadow <= 8'h00;
    end else if (software_defined_rate) begin
      sdr_shadow <= oneshot_sample_count_r;
    end else begin
      sdr_shadow <= 8'h00;
    end
  end

  // ==========================================================================
  // Offsets and gain high bits; factory image loaded on reset and on copy.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      x_offset_value_r <= X_OFFSET_FACTORY;
      y_offset_value_r <= Y_OFFSET_FACTORY;
      x_gain_msb_r     <= X_GAIN_FACTORY[8];
      y_gain_msb_r     <= Y_GAIN_FACTORY[8];
    end else if (reload_busy && copy_cnt_r == 5'h00) begin
      x_offset_value_r <= X_OFFSET_FACTORY;
      y_offset_value_r <= Y_OFFSET_FACTORY;
      x_gain_msb_r     <= X_GAIN_FACTORY[8];
      y_gain_msb_r     <= Y_GAIN_FACTORY[8];
    end else begin
      if (hit(`ADDR_X_OFF_LOW)) begin
        x_offset_value_r[7:0] <= wr_data;
      end
      if (hit(`ADDR_X_OFF_HIGH)) begin
        x_offset_value_r[14:8] <= wr_data[6:0];
        x_gain_msb_r           <= wr_data[`BIT_GAIN_MSB];
      end
      if (hit(`ADDR_Y_OFF_LOW)) begin
        y_offset_value_r[7:0] <= wr_data;
      end
      if (hit(`ADDR_Y_OFF_HIGH)) begin
        y_offset_value_r[14:8] <= wr_data[6:0];
        y_gain_msb_r           <= wr_data[`BIT_GAIN_MSB];
      end
    end
  end
  assign x_gain_value = {x_gain_msb_r, X_GAIN_FACTORY[7:0]};
  assign y_gain_value = {y_gain_msb_r, Y_GAIN_FACTORY[7:0]};

  // ==========================================================================
  // Offset-corrected results.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      x_extended_output <= 16'sh0000;
      y_extended_output <= 16'sh0000;
    end else begin
      x_extended_output <= add_off(x_accel, x_offset_value_r);
      y_extended_output <= add_off(y_accel, y_offset_value_r);
    end
  end

  // ==========================================================================
  // Mode field change detection ends continuous sampling.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mode_last_r <= 3'h0;
    end else begin
      mode_last_r <= mode_field;
    end
  end

  oneshot_sequencer u_seq (
    .clk         (clk),
    .rst_n       (rst_n),
    .trigger     (trigger && !software_defined_rate),
    .count       (oneshot_sample_count_r),
    .mode_change (mode_field != mode_last_r),
    .sample_tick (sample_tick),
    .sample_en   (sample_en),
    .seq_active  (seq_active)
  );

  // ==========================================================================
  // Read data, registered; offsets are write-only and read zero.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_data <= 8'h00;
    end else if (rd_en) begin
      case (addr)
        `ADDR_STATUS:     rd_data <= {2'b00, reload_busy, 5'h00};
        `ADDR_Z_DRIVE:    rd_data <= z_drive_register_r;
        `ADDR_SOFT_RESET: rd_data <= {reload_req_r, 7'h00};
        `ADDR_INIT_TWO:   rd_data <= init_zero_two_r;
        `ADDR_TRIG_COUNT: rd_data <= oneshot_sample_count_r;
        default:          rd_data <= 8'h00;
      endcase
    end
  end

  // ==========================================================================
  // Checks.
  drive_pos_a: assert property (@(posedge clk) disable iff (!rst_n)
    hit(`ADDR_Z_DRIVE) && !soft_rst_r |=> z_positive_drive == $past(wr_data[2]))
    else $error("positive drive does not follow written bit");
  drive_neg_a: assert property (@(posedge clk) disable iff (!rst_n)
    hit(`ADDR_Z_DRIVE) && !soft_rst_r |=> z_negative_drive == $past(wr_data[3]))
    else $error("negative drive does not follow written bit");
  soft_clear_a: assert property (@(posedge clk) disable iff (!rst_n)
    soft_go |=> soft_rst_r ##1 (!soft_rst_r && z_drive_register_r == 8'h00))
    else $error("forced reset did not clear drive or self-clear");
  wire_mode_a: assert property (@(posedge clk) disable iff (!rst_n)
    soft_rst_r |=> !spi_three_wire)
    else $error("serial port not back to four-wire after reset");
  busy_start_a: assert property (@(posedge clk) disable iff (!rst_n)
    reload_go && !reload_busy |=> reload_busy && busy_run_r == 5'h00)
    else $error("reload busy did not start after request");
  busy_len_a: assert property (@(posedge clk) disable iff (!rst_n)
    reload_busy |-> busy_run_r < 5'(`RELOAD_CYCLES))
    else $error("reload busy lasted too long");
  busy_end_a: assert property (@(posedge clk) disable iff (!rst_n)
    $fell(reload_busy) |-> busy_run_r == 5'(`RELOAD_CYCLES))
    else $error("reload busy ended early");
  reload_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
    reload_req_r && !hit(`ADDR_SOFT_RESET) && !soft_rst_r |=> reload_req_r)
    else $error("reload bit cleared without host write");
  offset_add_a: assert property (@(posedge clk) disable iff (!rst_n)
    rst_n |=> x_extended_output == $past(x_accel) + {$past(x_offset_value_r[14]),
                                                      $past(x_offset_value_r)})
    else $error("x offset not applied");
  y_offset_add_a: assert property (@(posedge clk) disable iff (!rst_n)
    rst_n |=> y_extended_output == $past(y_accel) + {$past(y_offset_value_r[14]),
                                                      $past(y_offset_value_r)})
    else $error("y offset not applied");
  status_read_a: assert property (@(posedge clk) disable iff (!rst_n)
    rd_en && addr == `ADDR_STATUS |=> rd_data[`BIT_BUSY] == $past(reload_busy))
    else $error("status busy bit does not match the copy engine");
  rst_read_a: assert property (@(posedge clk) disable iff (!rst_n)
    rd_en && addr == `ADDR_SOFT_RESET |=> rd_data[5:0] == 6'h00)
    else $error("reserved reset bits read nonzero");
  reload_cov_c: cover property (@(posedge clk) disable iff (!rst_n) reload_go);
  soft_cov_c:   cover property (@(posedge clk) disable iff (!rst_n) soft_go);
  x_offset_value_cov_c:   cover property (@(posedge clk) disable iff (!rst_n) hit(`ADDR_X_OFF_HIGH));
endmodule

// ===== verification/host_port_model.sv
// Host-side model of the register port: byte writes, byte reads, start-up duties.
`timescale 1ns/100ps
`include "accel_regs_defs.svh"
module host_port_model (
  input  wire logic       clk,
  output logic            wr_en,
  output logic            rd_en,
  output logic      [7:0] addr,
  output logic      [7:0] wr_data,
  input  wire logic [7:0] rd_data
);
  // ====================
  // Bus idle from time zero so the bank never sees a stray strobe.
  initial begin
    wr_en   = 1'b0;
    rd_en   = 1'b0;
    addr    = 8'h00;
    wr_data = 8'h00;
  end

  // One byte write; the data is scrambled once released so stale bytes never pass.
  task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    wr_en   <= 1'b1;
    addr    <= a;
    wr_data <= d;
    @(posedge clk);
    wr_en   <= 1'b0;
    wr_data <= ~d;
  endtask

  // One byte read; the answer is taken after the answering edge settles.
  task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    rd_en <= 1'b1;
    addr  <= a;
    @(posedge clk);
    rd_en <= 1'b0;
    #1;
    d = rd_data;
  endtask

  // Z drive writes always keep the reserved bits at zero.
  task automatic write_drive(input logic pos, input logic neg);
    write_reg(`ADDR_Z_DRIVE, {4'h0, neg, pos, 2'b00});
  endtask

  // Start-up duty after every reset.
  task automatic init_after_reset();
    write_reg(`ADDR_INIT_TWO, 8'h00);
  endtask

  // The reload request is dropped by the host once the copy is over.
  task automatic clear_reload();
    write_reg(`ADDR_SOFT_RESET, 8'h00);
  endtask
endmodule

// ===== verification/accel_test_reset_calib_regs_tb.sv
// Self-checking bench for the test, reset and calibration register bank.
`timescale 1ns/100ps
`include "accel_regs_defs.svh"
module accel_test_reset_calib_regs_tb import accel_regs_pkg::*;;
  // ====================
  // Factory image handed to the bank; values chosen to make sign and bit 8 visible.
  localparam logic [14:0] X_OFF  = 15'h7ff0;
  localparam logic [14:0] Y_OFF  = 15'h0123;
  localparam logic [8:0]  X_GAIN = 9'h1a5;
  localparam logic [8:0]  Y_GAIN = 9'h15a;
  logic               clk = 1'b0;
  logic               rst_n = 1'b0;
  logic               wr_en, rd_en;
  logic        [7:0]  addr, wr_data, rd_data, sdr_shadow;
  logic        [2:0]  mode_field = 3'h0;
  logic        [2:0]  rate_select = 3'h0;
  logic               software_defined_rate = 1'b0;
  logic               trigger = 1'b0;
  logic               sample_tick = 1'b0;
  logic signed [15:0] x_accel = 16'h0000;
  logic signed [15:0] y_accel = 16'h0000;
  logic               z_positive_drive, z_negative_drive, spi_three_wire, reload_busy;
  logic        [8:0]  x_gain_value, y_gain_value;
  logic signed [15:0] x_extended_output, y_extended_output;
  logic               sample_en, seq_active;
  int                 errors = 0;
  int                 n_compared = 0;
  int                 cycles = 0;
  int                 n_samples = 0;

  always #20 clk = ~clk;

  // Cycle ceiling cuts a hang short; sample pulses are tallied at each edge.
  always @(posedge clk) begin
    cycles++;
    if (sample_en === 1'b1) begin
      n_samples++;
    end
    if (cycles == 5000) begin
      errors++;
      report_and_stop();
    end
  end

  accel_test_reset_calib_regs #(.X_OFFSET_FACTORY(X_OFF), .Y_OFFSET_FACTORY(Y_OFF),
    .X_GAIN_FACTORY(X_GAIN), .Y_GAIN_FACTORY(Y_GAIN)) u_dut (
    .clk(clk), .rst_n(rst_n), .wr_en(wr_en), .rd_en(rd_en), .addr(addr),
    .wr_data(wr_data), .rd_data(rd_data), .mode_field(mode_field),
    .rate_select(rate_select), .software_defined_rate(software_defined_rate),
    .trigger(trigger), .sample_tick(sample_tick), .x_accel(x_accel), .y_accel(y_accel),
    .z_positive_drive(z_positive_drive), .z_negative_drive(z_negative_drive),
    .spi_three_wire(spi_three_wire), .reload_busy(reload_busy),
    .x_gain_value(x_gain_value), .y_gain_value(y_gain_value),
    .x_extended_output(x_extended_output), .y_extended_output(y_extended_output),
    .sdr_shadow(sdr_shadow), .sample_en(sample_en), .seq_active(seq_active));

  host_port_model u_host (.clk(clk), .wr_en(wr_en), .rd_en(rd_en), .addr(addr),
    .wr_data(wr_data), .rd_data(rd_data));

  // ====================
  // Shared comparison and verdict.
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      errors++;
      $display("FAIL %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic report_and_stop();
    if (errors == 0 && n_compared > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    u_host.read_reg(a, d);
    check(d, exp);
  endtask

  // Bounded wait for the copy engine; returns how many edges it took.
  task automatic wait_busy(output int n);
    n = 0;
    while (reload_busy === 1'b1 && n < 100) begin
      @(posedge clk);
      #1;
      n++;
    end
  endtask

  // New raw results; the sum is registered, so two edges pass before looking.
  task automatic settle(input logic [15:0] xa, input logic [15:0] ya);
    @(posedge clk);
    x_accel <= xa;
    y_accel <= ya;
    repeat (2) @(posedge clk);
    #1;
  endtask

  task automatic pulse_ticks(input int k);
    repeat (k) begin
      @(posedge clk);
      sample_tick <= 1'b1;
      @(posedge clk);
      sample_tick <= 1'b0;
    end
    repeat (4) @(posedge clk);
    #1;
  endtask

  // ====================
  // Scenarios.
  task automatic t_reset_values();
    #1;
    check(spi_three_wire, 1'b0);
    check(x_gain_value, X_GAIN);
    u_host.init_after_reset();
    rd_chk(`ADDR_Z_DRIVE, 8'h00);
    rd_chk(`ADDR_TRIG_COUNT, 8'h00);
    rd_chk(`ADDR_X_OFF_LOW, 8'h00);
    rd_chk(8'h40, 8'h00);
    rd_chk(`ADDR_INIT_TWO, 8'h00);
    settle(16'h0100, 16'h0100);
    check(x_extended_output, 16'h0100 + {X_OFF[14], X_OFF});
    check(y_gain_value, Y_GAIN);
  endtask

  // Every drive combination, including both directions at once.
  task automatic t_drive();
    for (int i = 0; i < 4; i++) begin
      u_host.write_drive(i[0], i[1]);
      #1;
      check(z_positive_drive, i[0]);
      check(z_negative_drive, i[1]);
      rd_chk(`ADDR_Z_DRIVE, {4'h0, i[1], i[0], 2'b00});
    end
  endtask

  // Reserved bits of the reset register must neither act nor stick.
  task automatic t_reserved();
    u_host.write_reg(`ADDR_SOFT_RESET, 8'h3f);
    #1;
    check(reload_busy, 1'b0);
    rd_chk(`ADDR_SOFT_RESET, 8'h00);
  endtask

  // Reload: status shows busy, request stays set, factory offsets arrive.
  task automatic t_reload();
    int n;
    u_host.write_reg(`ADDR_X_OFF_LOW, 8'h00);
    u_host.write_reg(`ADDR_X_OFF_HIGH, 8'h00);
    u_host.write_reg(`ADDR_SOFT_RESET, 8'h80);
    #1;
    check(reload_busy, 1'b1);
    rd_chk(`ADDR_STATUS, 8'h20);
    wait_busy(n);
    check(n, `RELOAD_CYCLES - 2);
    rd_chk(`ADDR_STATUS, 8'h00);
    rd_chk(`ADDR_SOFT_RESET, 8'h80);
    check(x_gain_value, X_GAIN);
    settle(16'h0100, 16'h0100);
    check(x_extended_output, 16'h0100 + {X_OFF[14], X_OFF});
    check(y_extended_output, 16'h0100 + {Y_OFF[14], Y_OFF});
    u_host.clear_reload();
    rd_chk(`ADDR_SOFT_RESET, 8'h00);
  endtask

  // Host-written offsets, negative one on Y, gain bit 8 set on X and cleared on Y.
  task automatic t_offsets();
    u_host.write_reg(`ADDR_X_OFF_LOW, 8'h34);
    u_host.write_reg(`ADDR_X_OFF_HIGH, 8'h85);
    u_host.write_reg(`ADDR_Y_OFF_LOW, 8'hff);
    u_host.write_reg(`ADDR_Y_OFF_HIGH, 8'h7f);
    settle(16'hff00, 16'h0010);
    check(x_extended_output, 16'h0434);
    check(y_extended_output, 16'h000f);
    check(x_gain_value, {1'b1, X_GAIN[7:0]});
    check(y_gain_value, {1'b0, Y_GAIN[7:0]});
    u_host.write_reg(`ADDR_X_OFF_LOW, 8'h00);
    settle(16'hff00, 16'h0010);
    check(x_extended_output, 16'h0400);
  endtask

  // Forced reset clears the bank, self-clears and reloads the factory image.
  task automatic t_soft_reset();
    int n;
    u_host.write_drive(1'b1, 1'b0);
    u_host.write_reg(`ADDR_SOFT_RESET, 8'h40);
    repeat (2) @(posedge clk);
    #1;
    check(z_positive_drive, 1'b0);
    check(reload_busy, 1'b1);
    wait_busy(n);
    rd_chk(`ADDR_SOFT_RESET, 8'h00);
    rd_chk(`ADDR_Z_DRIVE, 8'h00);
    check(spi_three_wire, 1'b0);
    settle(16'h0100, 16'h0100);
    check(x_extended_output, 16'h0100 + {X_OFF[14], X_OFF});
    u_host.init_after_reset();
  endtask

  // Count byte appears on the shadow only while software rate is chosen.
  task automatic t_sdr();
    u_host.write_reg(`ADDR_TRIG_COUNT, 8'h37);
    @(posedge clk);
    software_defined_rate <= 1'b1;
    rate_select <= 3'h5;
    repeat (2) @(posedge clk);
    #1;
    check(sdr_shadow, 8'h37);
    @(posedge clk);
    trigger <= 1'b1;
    @(posedge clk);
    trigger <= 1'b0;
    software_defined_rate <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
    check(seq_active, 1'b0);
    check(sdr_shadow, 8'h00);
  endtask

  // One-shot run with more ticks offered than the count allows, or a continuous run at count 255.
  task automatic t_count(input logic [7:0] cnt, input int ticks, input int exp);
    int start;
    u_host.write_reg(`ADDR_TRIG_COUNT, cnt);
    start = n_samples;
    @(posedge clk);
    trigger <= 1'b1;
    @(posedge clk);
    trigger <= 1'b0;
    pulse_ticks(ticks);
    check(n_samples - start, exp);
    check(seq_active, cnt == 8'hff);
  endtask

  initial begin
    int start;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    t_reset_values();
    t_drive();
    t_reserved();
    t_reload();
    t_offsets();
    t_soft_reset();
    t_sdr();
    t_count(8'd1, 4, 1);
    t_count(8'd3, 6, 3);
    t_count(8'd254, 257, 254);
    t_count(8'd0, 3, 0);
    t_count(8'hff, 20, 20);
    @(posedge clk);
    mode_field <= 3'h3;
    start = n_samples;
    pulse_ticks(5);
    check(n_samples - start, 0);
    check(seq_active, 1'b0);
    report_and_stop();
  end
endmodule
